/* File: core/ubf_config.sv */
// serial port baud and frame configuration with apb register file
//
// Functional notes
// - the high divisor write is buffered and committed only by a low write.
// - divisor upper five bits are high reg bits 4..0, lower eight the low reg.
// - a zero divisor stops the baud generator entirely.
// - a divisor of 1..8191 gives a baud of the bus clock over sixteen times it.
// - after reset the generator stays off until rx or tx is first enabled.
// - break interrupt enable requests an interrupt while the break flag is 1.
// - edge interrupt enable requests an interrupt while the edge flag is 1.
// - stop select gives one stop bit at 0 and two at 1.
// - loopback routes transmitter output to the receiver, ignoring rx pin.
// - with loopback off, rx and tx use separate pins.
// - wait freeze 0 keeps clocks in wait; 1 freezes them during wait.
// - low divisor resets to 04h, high divisor and frame control to zero.
// - in loopback, source select 0 is internal loop, 1 is single wire.
// - nine-bit select adds a ninth data bit before the stop bit.
// - with parity on the top data bit is parity; 0 even, 1 odd.
//
// The APB slave port and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
module ubf_config
	import ubf_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst_b,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        breakFlag,
	input  wire logic        rxEdgeFlag,
	input  wire logic        txSerial,
	input  wire logic        rxPin,
	input  wire logic        txPinIn,
	input  wire logic        cpuWait,
	output logic             txPinOut,
	output logic             txPinOe,
	output logic             rxToReceiver,
	output logic             breakIrq,
	output logic             rxEdgeIrq,
	output logic             irq,
	output logic             baudTick,
	output logic             bitTick,
	output logic             clockRun,
	output logic             twoStopBits,
	output logic             nineBitChar,
	output logic             parityOn,
	output logic             oddParitySel,
	output logic             idleCountStartSel,
	output logic             wakeAddrMark
);
	logic [7:0] divHighBuf_r;   // buffered high half as written
	logic [4:0] divHighWork_r;  // working high half
	logic [7:0] divLow_r;
	logic [7:0] frameCtrl_r;
	logic [1:0] enable_r;
	logic       genArmed_r;
	logic [1:0] irqStat_r;
	logic [1:0] irqMask_r;
	logic [1:0] brkSync_r;
	logic [1:0] edgSync_r;
	logic [1:0] rxSync_r;
	logic [1:0] txInSync_r;
	logic [1:0] waitSync_r;
	ubf_bus_t   busState_r;
	ubf_bus_t   busState_nxt;
	ubf_route_t route;
	logic [31:0] rdMux;
	logic        addrOk;
	logic        wrEn;
	logic        rdEn;
	logic        rxSel;
	logic        genRun;

	ubf_baud_if bIf ();

	ubf_baud_gen u_gen (
		.clk   (clk),
		.rst_b (rst_b),
		.bg    (bIf.gen)
	);

	// apb handshake: one wait state, answer in the cycle after access starts
	always_comb begin
		busState_nxt = busState_r;
		case (busState_r)
			UBF_BUS_IDLE: begin
				if (psel && !penable)
					busState_nxt = UBF_BUS_ACCESS;
			end
			UBF_BUS_ACCESS: begin
				if (psel && penable)
					busState_nxt = UBF_BUS_DONE;
			end
			UBF_BUS_DONE: busState_nxt = UBF_BUS_IDLE;
			default: busState_nxt = UBF_BUS_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_b)
			busState_r <= UBF_BUS_IDLE;
		else
			busState_r <= busState_nxt;
	end

	// address decode; a commit happens on the access edge that sees pready
	always_comb begin
		addrOk = (paddr == UBF_DIV_HIGH_OFS) || (paddr == UBF_DIV_LOW_OFS)
			|| (paddr == UBF_FRAME_CTRL_OFS) || (paddr == UBF_ENABLE_OFS)
			|| (paddr == UBF_IRQ_STAT_OFS) || (paddr == UBF_IRQ_MASK_OFS)
			|| (paddr == UBF_LINE_STAT_OFS);
		wrEn = psel && penable && pready && pwrite && addrOk;
		rdEn = psel && penable && pready && !pwrite && addrOk;
	end

	// read mux of current state
	always_comb begin
		rdMux = 32'h0000_0000;
		case (paddr)
			UBF_DIV_HIGH_OFS:   rdMux = {24'h000000, divHighBuf_r};
			UBF_DIV_LOW_OFS:    rdMux = {24'h000000, divLow_r};
			UBF_FRAME_CTRL_OFS: rdMux = {24'h000000, frameCtrl_r};
			UBF_ENABLE_OFS:     rdMux = {30'h00000000, enable_r};
			UBF_IRQ_STAT_OFS:   rdMux = {30'h00000000, irqStat_r};
			UBF_IRQ_MASK_OFS:   rdMux = {30'h00000000, irqMask_r};
			UBF_LINE_STAT_OFS:  rdMux = {29'h00000000, genRun,
				edgSync_r[1], brkSync_r[1]};
			default: rdMux = 32'h0000_0000;
		endcase
	end

	// bus outputs registered
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= (busState_nxt == UBF_BUS_DONE);
			pslverr <= (busState_nxt == UBF_BUS_DONE) && !addrOk;
			prdata  <= (busState_nxt == UBF_BUS_DONE) ? rdMux : 32'h0000_0000;
		end
	end

	// divisor registers: high buffered, committed with low write
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			divHighBuf_r  <= UBF_DIV_HIGH_RST;
			divHighWork_r <= UBF_DIV_HIGH_RST[UBF_DIV_HI_MSB:0];
			divLow_r      <= UBF_DIV_LOW_RST;
		end else if (wrEn && paddr == UBF_DIV_HIGH_OFS) begin
			divHighBuf_r <= pwdata[7:0];
		end else if (wrEn && paddr == UBF_DIV_LOW_OFS) begin
			divLow_r      <= pwdata[7:0];
			divHighWork_r <= divHighBuf_r[UBF_DIV_HI_MSB:0];
		end
	end

	// frame control and enable registers
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			frameCtrl_r <= UBF_FRAME_CTRL_RST;
			enable_r    <= 2'b00;
			irqMask_r   <= 2'b00;
		end else if (wrEn) begin
			if (paddr == UBF_FRAME_CTRL_OFS)
				frameCtrl_r <= pwdata[7:0];
			if (paddr == UBF_ENABLE_OFS)
				enable_r <= pwdata[1:0];
			if (paddr == UBF_IRQ_MASK_OFS)
				irqMask_r <= pwdata[1:0];
		end
	end

	// generator stays off after reset until rx or tx is first enabled
	always_ff @(posedge clk) begin
		if (!rst_b)
			genArmed_r <= 1'b0;
		else if (wrEn && paddr == UBF_ENABLE_OFS && pwdata[1:0] != 2'b00)
			genArmed_r <= 1'b1;
	end

	// input synchronisers for pins and flags from outside
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			brkSync_r  <= 2'b00;
			edgSync_r  <= 2'b00;
			rxSync_r   <= 2'b11;
			txInSync_r <= 2'b11;
			waitSync_r <= 2'b00;
		end else begin
			brkSync_r  <= {brkSync_r[0], breakFlag};
			edgSync_r  <= {edgSync_r[0], rxEdgeFlag};
			rxSync_r   <= {rxSync_r[0], rxPin};
			txInSync_r <= {txInSync_r[0], txPinIn};
			waitSync_r <= {waitSync_r[0], cpuWait};
		end
	end

	// sticky status; a read clears, but a new event in that cycle wins
	always_ff @(posedge clk) begin
		if (!rst_b)
			irqStat_r <= 2'b00;
		else if (rdEn && paddr == UBF_IRQ_STAT_OFS)
			irqStat_r <= {rxEdgeIrq, breakIrq};
		else
			irqStat_r <= irqStat_r | {rxEdgeIrq, breakIrq};
	end

	// line routing selection
	always_comb begin
		if (!frameCtrl_r[UBF_LOOP_BIT])
			route = UBF_ROUTE_NORMAL;
		else if (frameCtrl_r[UBF_RXSRC_BIT])
			route = UBF_ROUTE_SINGLE;
		else
			route = UBF_ROUTE_LOOP;
		case (route)
			UBF_ROUTE_NORMAL: rxSel = rxSync_r[1];
			UBF_ROUTE_LOOP:   rxSel = txSerial;
			UBF_ROUTE_SINGLE: rxSel = txInSync_r[1];
			default:          rxSel = 1'b1;
		endcase
		genRun = genArmed_r && !(waitSync_r[1]
			&& frameCtrl_r[UBF_WAITFRZ_BIT]);
	end

	assign bIf.divisor = {divHighWork_r, divLow_r};
	assign bIf.run     = genRun;

	// registered outputs: routing, requests, ticks and clock run
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			txPinOut     <= 1'b1;
			txPinOe      <= 1'b0;
			rxToReceiver <= 1'b1;
			breakIrq     <= 1'b0;
			rxEdgeIrq    <= 1'b0;
			irq          <= 1'b0;
			baudTick     <= 1'b0;
			bitTick      <= 1'b0;
			clockRun     <= 1'b0;
		end else begin
			txPinOut     <= txSerial;
			txPinOe      <= (route != UBF_ROUTE_LOOP);
			rxToReceiver <= rxSel;
			breakIrq     <= brkSync_r[1] & divHighBuf_r[UBF_BRK_IE_BIT];
			rxEdgeIrq    <= edgSync_r[1] & divHighBuf_r[UBF_EDGE_IE_BIT];
			irq          <= |(irqStat_r & irqMask_r);
			baudTick     <= bIf.tick;
			bitTick      <= bIf.bitTick;
			clockRun     <= genRun && (bIf.divisor != '0);
		end
	end

	// frame settings handed to the shifters
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			twoStopBits       <= 1'b0;
			nineBitChar       <= 1'b0;
			parityOn          <= 1'b0;
			oddParitySel      <= 1'b0;
			idleCountStartSel <= 1'b0;
			wakeAddrMark      <= 1'b0;
		end else begin
			twoStopBits       <= divHighBuf_r[UBF_STOP_SEL_BIT];
			nineBitChar       <= frameCtrl_r[UBF_NINE_BIT];
			parityOn          <= frameCtrl_r[UBF_PAR_ON_BIT];
			oddParitySel      <= frameCtrl_r[UBF_PAR_ODD_BIT];
			idleCountStartSel <= frameCtrl_r[UBF_IDLE_SEL_BIT];
			wakeAddrMark      <= frameCtrl_r[UBF_WAKE_BIT];
		end
	end

	// checks beside the logic
	sequence hiWrite_s;
		wrEn && paddr == UBF_DIV_HIGH_OFS;
	endsequence

	sequence loWrite_s;
		wrEn && paddr == UBF_DIV_LOW_OFS;
	endsequence

	divisor_commit_a: assert property (@(posedge clk) disable iff (!rst_b)
		loWrite_s |=> bIf.divisor == {$past(divHighBuf_r[4:0]), $past(pwdata[7:0])})
		else $error("divisor not committed on low write");

	high_buffered_a: assert property (@(posedge clk) disable iff (!rst_b)
		hiWrite_s |=> $stable(divHighWork_r))
		else $error("high half applied before low write");

	zero_stop_a: assert property (@(posedge clk) disable iff (!rst_b)
		bIf.divisor == '0 |-> ##2 !baudTick)
		else $error("baud tick with zero divisor");

	unarmed_off_a: assert property (@(posedge clk) disable iff (!rst_b)
		!genArmed_r |=> !clockRun)
		else $error("generator ran before enable");

	break_irq_a: assert property (@(posedge clk) disable iff (!rst_b)
		breakIrq == $past(brkSync_r[1] & divHighBuf_r[7]))
		else $error("break request wrong");

	edge_irq_a: assert property (@(posedge clk) disable iff (!rst_b)
		rxEdgeIrq |-> $past(divHighBuf_r[6]))
		else $error("edge request without enable");

	stop_sel_a: assert property (@(posedge clk) disable iff (!rst_b)
		twoStopBits == $past(divHighBuf_r[5]))
		else $error("stop select wrong");

	loop_route_a: assert property (@(posedge clk) disable iff (!rst_b)
		route == UBF_ROUTE_LOOP |=> rxToReceiver == $past(txSerial))
		else $error("loopback routing wrong");

	normal_route_a: assert property (@(posedge clk) disable iff (!rst_b)
		route == UBF_ROUTE_NORMAL |=> rxToReceiver == $past(rxSync_r[1]))
		else $error("normal routing wrong");

	freeze_stop_a: assert property (@(posedge clk) disable iff (!rst_b)
		waitSync_r[1] && frameCtrl_r[UBF_WAITFRZ_BIT] |=> !clockRun)
		else $error("generator ran while frozen in wait");

	single_route_a: assert property (@(posedge clk) disable iff (!rst_b)
		route == UBF_ROUTE_SINGLE |=> rxToReceiver == $past(txInSync_r[1]))
		else $error("single wire routing wrong");

	nine_bit_a: assert property (@(posedge clk) disable iff (!rst_b)
		nineBitChar == $past(frameCtrl_r[UBF_NINE_BIT]))
		else $error("nine bit select wrong");

	parity_sel_a: assert property (@(posedge clk) disable iff (!rst_b)
		{parityOn, oddParitySel}
			== $past(frameCtrl_r[UBF_PAR_ON_BIT:UBF_PAR_ODD_BIT]))
		else $error("parity settings wrong");
endmodule
`default_nettype wire

/* File: pkg/ubf_pkg.sv */
// constants and types for the serial port baud and frame configuration
package ubf_pkg;
	// register offsets (byte addresses on apb)
	localparam logic [11:0] UBF_DIV_HIGH_OFS   = 12'h000;
	localparam logic [11:0] UBF_DIV_LOW_OFS    = 12'h004;
	localparam logic [11:0] UBF_FRAME_CTRL_OFS = 12'h008;
	localparam logic [11:0] UBF_ENABLE_OFS     = 12'h00C;
	localparam logic [11:0] UBF_IRQ_STAT_OFS   = 12'h010;
	localparam logic [11:0] UBF_IRQ_MASK_OFS   = 12'h014;
	localparam logic [11:0] UBF_LINE_STAT_OFS  = 12'h018;
	// reset values
	localparam logic [7:0] UBF_DIV_HIGH_RST   = 8'h00;
	localparam logic [7:0] UBF_DIV_LOW_RST    = 8'h04;
	localparam logic [7:0] UBF_FRAME_CTRL_RST = 8'h00;
	// divisor high register fields
	localparam int UBF_BRK_IE_BIT   = 7;
	localparam int UBF_EDGE_IE_BIT  = 6;
	localparam int UBF_STOP_SEL_BIT = 5;
	localparam int UBF_DIV_HI_MSB   = 4;
	// frame control fields
	localparam int UBF_LOOP_BIT     = 7;
	localparam int UBF_WAITFRZ_BIT  = 6;
	localparam int UBF_RXSRC_BIT    = 5;
	localparam int UBF_NINE_BIT     = 4;
	localparam int UBF_WAKE_BIT     = 3;
	localparam int UBF_IDLE_SEL_BIT = 2;
	localparam int UBF_PAR_ON_BIT   = 1;
	localparam int UBF_PAR_ODD_BIT  = 0;
	// enable register fields
	localparam int UBF_RX_ON_BIT = 1;
	localparam int UBF_TX_ON_BIT = 0;
	// timing: baud generator divides by sixteen times the divisor
	localparam int UBF_OVERSAMPLE = 16;
	localparam int UBF_DIV_W      = 13;
	// line routing modes
	typedef enum logic [1:0] {
		UBF_ROUTE_NORMAL = 2'b00,
		UBF_ROUTE_LOOP   = 2'b01,
		UBF_ROUTE_SINGLE = 2'b10
	} ubf_route_t;
	// apb slave states
	typedef enum logic [1:0] {
		UBF_BUS_IDLE   = 2'b00,
		UBF_BUS_ACCESS = 2'b01,
		UBF_BUS_DONE   = 2'b10
	} ubf_bus_t;
endpackage

/* File: pkg/ubf_baud_if.sv */
// interface between the configuration core and its baud generator
`timescale 1ns/1ps
`default_nettype none
interface ubf_baud_if;
	import ubf_pkg::*;
	logic [UBF_DIV_W-1:0] divisor;
	logic                 run;
	logic                 tick;
	logic                 bitTick;
	modport core (output divisor, output run, input tick, input bitTick);
	modport gen  (input divisor, input run, output tick, output bitTick);
endinterface
`default_nettype wire

/* File: core/ubf_baud_gen.sv */
// baud generator: sixteen-times oversample tick and bit tick
`timescale 1ns/1ps
`default_nettype none
module ubf_baud_gen
	import ubf_pkg::*;
(
	input  wire logic clk,
	input  wire logic rst_b,
	ubf_baud_if.gen   bg
);
	logic [UBF_DIV_W-1:0] divCnt_r;
	logic [3:0]           ovsCnt_r;
	logic                 tick_r;
	logic                 bit_r;

	// divide counter, held at zero while stopped so it draws no toggling
	always_ff @(posedge clk) begin
		if (!rst_b || !bg.run || bg.divisor == '0) begin
			divCnt_r <= '0;
			tick_r   <= 1'b0;
		end else if (divCnt_r >= bg.divisor - 13'h0001) begin
			divCnt_r <= '0;
			tick_r   <= 1'b1;
		end else begin
			divCnt_r <= divCnt_r + 13'h0001;
			tick_r   <= 1'b0;
		end
	end

	// oversample counter gives one bit tick per sixteen ticks
	always_ff @(posedge clk) begin
		if (!rst_b || !bg.run || bg.divisor == '0) begin
			ovsCnt_r <= 4'h0;
			bit_r    <= 1'b0;
		end else if (tick_r) begin
			ovsCnt_r <= ovsCnt_r + 4'h1;
			bit_r    <= (ovsCnt_r == 4'(UBF_OVERSAMPLE - 1));
		end else begin
			bit_r <= 1'b0;
		end
	end

	assign bg.tick    = tick_r;
	assign bg.bitTick = bit_r;
endmodule
`default_nettype wire

/* File: tb/ubf_line_partner.sv */
// far-side serial transceiver model on the receive and shared pins
`timescale 1ns/1ps
`default_nettype none
module ubf_line_partner (
	input  wire logic lineLvl,
	input  wire logic txPinOut,
	input  wire logic txPinOe,
	output logic      rxPin,
	output logic      txPinIn
);
	// remote transmitter owns the receive pin on its own wire
	assign rxPin = lineLvl;
	// shared pin: device drives while enabled, remote end otherwise
	assign txPinIn = txPinOe ? txPinOut : lineLvl;
endmodule
`default_nettype wire

/* File: tb/uart_baud_frame_config_tb_top.sv */
// self-checking bench for the baud and frame configuration block
`timescale 1ns/1ps
`default_nettype none
module uart_baud_frame_config_tb_top
	import ubf_pkg::*;
;
	typedef struct {
		logic [11:0] a;
		logic [7:0]  d;
		logic [5:0]  s;
	} ubf_row_t;
	logic        clk, rst_b, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic        breakFlag, rxEdgeFlag, txSerial, rxPin, txPinIn, cpuWait;
	logic        txPinOut, txPinOe, rxToReceiver, breakIrq, rxEdgeIrq;
	logic        irq, baudTick, bitTick, clockRun, lineLvl;
	logic        twoStop, nine, parOn, parOdd, idleSel, wake;
	int          numErrors, checksDone;
	logic [31:0] rdv;
	logic        rde;
	// settings rows: address, write value, expected setting outputs
	ubf_row_t rows[8] = '{
		'{UBF_FRAME_CTRL_OFS, 8'h10, 6'h10},
		'{UBF_FRAME_CTRL_OFS, 8'h08, 6'h01},
		'{UBF_FRAME_CTRL_OFS, 8'h04, 6'h02},
		'{UBF_FRAME_CTRL_OFS, 8'h02, 6'h08},
		'{UBF_FRAME_CTRL_OFS, 8'h03, 6'h0C},
		'{UBF_FRAME_CTRL_OFS, 8'h00, 6'h00},
		'{UBF_DIV_HIGH_OFS,   8'h20, 6'h20},
		'{UBF_DIV_HIGH_OFS,   8'h00, 6'h00}};

	ubf_config ubf_config_inst (.clk(clk), .rst_b(rst_b), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .breakFlag(breakFlag), .rxEdgeFlag(rxEdgeFlag),
		.txSerial(txSerial), .rxPin(rxPin), .txPinIn(txPinIn),
		.cpuWait(cpuWait), .txPinOut(txPinOut), .txPinOe(txPinOe),
		.rxToReceiver(rxToReceiver), .breakIrq(breakIrq),
		.rxEdgeIrq(rxEdgeIrq), .irq(irq), .baudTick(baudTick),
		.bitTick(bitTick), .clockRun(clockRun), .twoStopBits(twoStop),
		.nineBitChar(nine), .parityOn(parOn), .oddParitySel(parOdd),
		.idleCountStartSel(idleSel), .wakeAddrMark(wake));
	ubf_line_partner ubf_line_partner_inst (.lineLvl(lineLvl),
		.txPinOut(txPinOut), .txPinOe(txPinOe), .rxPin(rxPin),
		.txPinIn(txPinIn));

	// 125 MHz bus clock
	always #4 clk = ~clk;

	// verdict and end of run
	task stopTest;
		if (numErrors == 0 && checksDone > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// a wait that ran out of bound
	task tmo;
		numErrors++;
		$display("ERROR %0t: wait timed out", $time);
		stopTest;
	endtask

	// compare seen against expected
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checksDone++;
		if (got !== exp) begin
			numErrors++;
			$display("ERROR %0t: got %h exp %h", $time, got, exp);
		end
	endtask

	// one apb transfer, held until pready is sampled high
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		@(posedge clk);
		while (pready !== 1'b1) begin
			n = n + 1;
			if (n > 20)
				tmo;
			@(posedge clk);
		end
		rdv = prdata;
		rde = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask

	task wr(input logic [11:0] a, input logic [7:0] d);
		apb(1'b1, a, {24'h0, d});
	endtask

	task rd(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rdv, exp);
	endtask

	// cycles between two pulses of the baud or the bit tick
	task per(input logic sel, input int exp);
		int c;
		c = 0;
		@(posedge clk);
		while ((sel ? bitTick : baudTick) !== 1'b1) begin
			c = c + 1;
			if (c > 600)
				tmo;
			@(posedge clk);
		end
		c = 1;
		@(posedge clk);
		while ((sel ? bitTick : baudTick) !== 1'b1) begin
			c = c + 1;
			if (c > 600)
				tmo;
			@(posedge clk);
		end
		chk(c, exp);
	endtask

	// main sequence
	initial begin
		clk = 1'b0;
		rst_b = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
		breakFlag = 1'b0;
		rxEdgeFlag = 1'b0;
		txSerial = 1'b1;
		cpuWait = 1'b0;
		lineLvl = 1'b1;
		numErrors = 0;
		checksDone = 0;
		repeat (10) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		rd(UBF_DIV_HIGH_OFS, 32'h0);
		rd(UBF_DIV_LOW_OFS, 32'h4);
		rd(UBF_FRAME_CTRL_OFS, 32'h0);
		chk(clockRun, 1'b0);
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].d);
			rd(rows[i].a, {24'h0, rows[i].d});
			chk({twoStop, nine, parOn, parOdd, idleSel, wake}, rows[i].s);
		end
		// arming with the reset divisor of four
		wr(UBF_ENABLE_OFS, 8'h02);
		repeat (2) @(posedge clk);
		chk(clockRun, 1'b1);
		per(1'b0, 4);
		wr(UBF_DIV_HIGH_OFS, 8'h01);
		per(1'b0, 4);
		wr(UBF_DIV_LOW_OFS, 8'h00);
		per(1'b0, 256);
		wr(UBF_DIV_HIGH_OFS, 8'h00);
		wr(UBF_DIV_LOW_OFS, 8'h02);
		per(1'b0, 2);
		per(1'b1, 32);
		// wait mode with and without freeze
		cpuWait <= 1'b1;
		repeat (5) @(posedge clk);
		chk(clockRun, 1'b1);
		wr(UBF_FRAME_CTRL_OFS, 8'h40);
		repeat (2) @(posedge clk);
		chk(clockRun, 1'b0);
		cpuWait <= 1'b0;
		repeat (5) @(posedge clk);
		chk(clockRun, 1'b1);
		wr(UBF_DIV_LOW_OFS, 8'h00);
		repeat (2) @(posedge clk);
		chk(clockRun, 1'b0);
		// line routing: loop, single wire, separate pins
		txSerial <= 1'b0;
		wr(UBF_FRAME_CTRL_OFS, 8'h80);
		repeat (5) @(posedge clk);
		chk({txPinOe, rxToReceiver}, 2'b00);
		wr(UBF_FRAME_CTRL_OFS, 8'hA0);
		repeat (5) @(posedge clk);
		chk({txPinOe, rxToReceiver}, 2'b10);
		wr(UBF_FRAME_CTRL_OFS, 8'h00);
		repeat (5) @(posedge clk);
		chk({txPinOe, txPinOut, rxToReceiver}, 3'b101);
		txSerial <= 1'b1;
		// interrupt requests from flags and enables
		breakFlag <= 1'b1;
		repeat (5) @(posedge clk);
		chk({breakIrq, rxEdgeIrq}, 2'b00);
		wr(UBF_DIV_HIGH_OFS, 8'hC0);
		repeat (4) @(posedge clk);
		chk({breakIrq, rxEdgeIrq}, 2'b10);
		rxEdgeFlag <= 1'b1;
		repeat (4) @(posedge clk);
		chk({breakIrq, rxEdgeIrq}, 2'b11);
		rd(UBF_LINE_STAT_OFS, 32'h7);
		wr(UBF_DIV_HIGH_OFS, 8'h00);
		repeat (2) @(posedge clk);
		chk({breakIrq, rxEdgeIrq}, 2'b00);
		breakFlag <= 1'b0;
		rxEdgeFlag <= 1'b0;
		repeat (4) @(posedge clk);
		chk(irq, 1'b0);
		wr(UBF_IRQ_MASK_OFS, 8'h03);
		repeat (2) @(posedge clk);
		chk(irq, 1'b1);
		rd(UBF_IRQ_STAT_OFS, 32'h3);
		repeat (2) @(posedge clk);
		chk(irq, 1'b0);
		rd(UBF_IRQ_STAT_OFS, 32'h0);
		// a flag still high when status is read sets it again
		breakFlag <= 1'b1;
		wr(UBF_DIV_HIGH_OFS, 8'h80);
		repeat (4) @(posedge clk);
		rd(UBF_IRQ_STAT_OFS, 32'h1);
		rd(UBF_IRQ_STAT_OFS, 32'h1);
		// unmapped address is refused
		rd(12'h01C, 32'h0);
		chk(rde, 1'b1);
		stopTest;
	end
endmodule
`default_nettype wire
